/* File: hw/etwd_pkg.sv */
/*
 * Types shared by the timer and watchdog block.
 * Assumes the register header is on the include path.
 */
package etwd_pkg;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [0:0] {
		WD_IDLE = 1'b0,
		WD_RUN  = 1'b1
	} wd_state_t;

endpackage

/* File: hw/etwd_regs.svh */
/*
 * Register offsets, field positions, reset values and timing constants of the timer and watchdog block.
 * Assumes inclusion by bare name from the design module and the checker.
 */
`ifndef ETWD_REGS_SVH
`define ETWD_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CONFIG        8'h01
`define OFF_PRESCALE      8'h02
`define OFF_TCOUNT_HIGH   8'h03
`define OFF_TCOUNT_LOW    8'h04
`define OFF_CONTROL       8'h05
`define OFF_WCOUNT_LOW    8'h06
`define OFF_WKEY          8'h07
`define OFF_SCRATCH       8'h08
`define OFF_WCOUNT_HIGH   8'h09
`define OFF_VERSION       8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_LOCK_CONFIG   0
`define CFG_LOCK_PRESCALE 1
`define CFG_LOCK_TIMER    2
`define CFG_LOCK_WDOG     3
`define CFG_CLOCK_SELECT  4
`define CFG_KEY_ENABLE    5
`define CFG_PAUSE         6
`define CTRL_RESTART      0

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define CONFIG_RESET      8'h00
`define PRESCALE_RESET    2'h0
`define TCOUNT_RESET      8'hFF
`define WCOUNT_RESET      8'hFF
`define WDOG_KEY          8'h5C
`define PS_32K            2'h0
`define PS_1K             2'h1
`define PS_32HZ           2'h2

// Base tick rate and its divisors for the slower prescaler settings.
`define RTC_HZ            32768
`define DIV_1K            32
`define DIV_32HZ          1024

`endif

/* File: hw/external_timer_watchdog.sv */
/*
 * Periodic timer with prescaler and a 16-bit count-down watchdog, reached through the controller's
 * byte register port.
 * Assumes rtc_tick is a one-cycle pulse at 32.768 kHz synchronous to ref_clk, and that register writes
 * and reads are single-cycle strobes with the address and data valid in the same cycle.
 */
`timescale 1ns/1ns
`include "etwd_regs.svh"

// Contract
// - Watchdog is a 16-bit down counter
// - Config bit 4 picks watchdog tick source
// - Idle after reset, count write starts
// - Count reaching zero asserts watchdog reset
// - Watchdog waits until timer is started
// - Count write reloads unless count locked
// - Key 5Ch restarts watchdog count
// - Config bit 5 enables key restart
// - Wrong key immediately asserts watchdog reset
// - Config bit 6 pauses during host cycles
// - Bit 3 locks watchdog count low byte writes
// - Bit 2 locks timer count writes
// - Bit 1 locks prescaler select writes
// - Bit 0 locks configuration register writes
// - Prescaler select: 32k, 1k, 32Hz
// - No prescaler output before low byte write
// - Timer starts on low byte write
// - Timer zero raises interrupt and reloads
// - Control restart bit reloads the timer
module external_timer_watchdog #(
	parameter int COUNT_WIDTH = 16,
	parameter logic [7:0] VERSION_CODE = 8'h01  // Arbitrary value.
) (
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire etwd_pkg::reg_req_t req,
	input  wire logic              rtc_tick,
	input  wire logic              host_memory_cycle,
	output logic [7:0]             rdata,
	output logic                   timer_irq,
	output logic                   watchdog_reset
);
	import etwd_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]             config_reg,    next_config_reg;
	logic [1:0]             prescale,      next_prescale;
	logic [7:0]             tcount_high,   next_tcount_high;
	logic [7:0]             tcount_low,    next_tcount_low;
	logic [7:0]             wcount_high,   next_wcount_high;
	logic [7:0]             wcount_low,    next_wcount_low;
	logic [7:0]             scratch,       next_scratch;
	logic                   timer_started, next_timer_started;
	logic [9:0]             div_count,     next_div_count;
	logic [COUNT_WIDTH-1:0] timer_count,   next_timer_count;
	logic [COUNT_WIDTH-1:0] wd_count,      next_wd_count;
	wd_state_t              wd_state,      next_wd_state;
	logic [7:0]             next_rdata;
	logic                   next_timer_irq;
	logic                   next_watchdog_reset;

	logic wr_config;
	logic wr_prescale;
	logic wr_tlow;
	logic wr_thigh;
	logic wr_wlow;
	logic wr_key;
	logic timer_restart;
	logic ps_tick;
	logic timer_expire;
	logic wd_tick;
	logic wd_touch;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_comb begin
		wr_config   = req.write && req.addr == `OFF_CONFIG && !config_reg[`CFG_LOCK_CONFIG];
		wr_prescale = req.write && req.addr == `OFF_PRESCALE && !config_reg[`CFG_LOCK_PRESCALE];
		wr_thigh    = req.write && req.addr == `OFF_TCOUNT_HIGH && !config_reg[`CFG_LOCK_TIMER];
		wr_tlow     = req.write && req.addr == `OFF_TCOUNT_LOW && !config_reg[`CFG_LOCK_TIMER];
		wr_wlow     = req.write && req.addr == `OFF_WCOUNT_LOW && !config_reg[`CFG_LOCK_WDOG];
		wr_key      = req.write && req.addr == `OFF_WKEY;
		timer_restart = req.write && req.addr == `OFF_CONTROL && req.wdata[`CTRL_RESTART];

		next_config_reg  = config_reg;
		next_prescale    = prescale;
		next_tcount_high = tcount_high;
		next_tcount_low  = tcount_low;
		next_wcount_high = wcount_high;
		next_wcount_low  = wcount_low;
		next_scratch     = scratch;
		if (wr_config) begin
			next_config_reg = {1'b0, req.wdata[6:4], req.wdata[3:0] | config_reg[3:0]};
		end
		if (wr_prescale) begin
			next_prescale = req.wdata[1:0];
		end
		if (wr_thigh) begin
			next_tcount_high = req.wdata;
		end
		if (wr_tlow) begin
			next_tcount_low = req.wdata;
		end
		// The high byte has no lock of its own; it takes effect on the next low byte write or key restart.
		if (req.write && req.addr == `OFF_WCOUNT_HIGH) begin
			next_wcount_high = req.wdata;
		end
		if (wr_wlow) begin
			next_wcount_low = req.wdata;
		end
		if (req.write && req.addr == `OFF_SCRATCH) begin
			next_scratch = req.wdata;
		end
	end

	// ----------------------------------------
	// Prescaler and periodic timer
	// ----------------------------------------
	// The divider is cleared only on a start or on a wrap. A prescaler change while the timer runs
	// therefore applies from the next tick, but its first period counts on from the divider's current value.
	always_comb begin
		next_timer_started = timer_started;
		next_div_count     = div_count;
		next_timer_count   = timer_count;
		ps_tick            = 1'b0;
		if (timer_started && rtc_tick) begin
			case (prescale)
				`PS_32K: begin
					ps_tick = 1'b1;
				end
				`PS_1K: begin
					ps_tick = div_count[4:0] == 5'(`DIV_1K - 1);
				end
				`PS_32HZ: begin
					ps_tick = div_count == 10'(`DIV_32HZ - 1);
				end
				default: begin
					ps_tick = 1'b0;
				end
			endcase
			next_div_count = ps_tick ? 10'h000 : div_count + 10'h001;
		end
		timer_expire = timer_started && ps_tick && timer_count == '0;
		if (wr_tlow) begin
			next_timer_started = 1'b1;
			next_timer_count   = COUNT_WIDTH'({tcount_high, req.wdata});
			next_div_count     = 10'h000;
		end else if (timer_restart && timer_started) begin
			next_timer_count = COUNT_WIDTH'({tcount_high, tcount_low});
		end else if (timer_expire) begin
			next_timer_count = COUNT_WIDTH'({tcount_high, tcount_low});
		end else if (timer_started && ps_tick) begin
			next_timer_count = timer_count - COUNT_WIDTH'(1);
		end
		next_timer_irq = timer_expire;
	end

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	always_comb begin
		wd_tick = config_reg[`CFG_CLOCK_SELECT] ? ps_tick : timer_expire;
		if (config_reg[`CFG_PAUSE] && host_memory_cycle) begin
			wd_tick = 1'b0;
		end
		wd_touch = wr_key && req.wdata == `WDOG_KEY && config_reg[`CFG_KEY_ENABLE];

		next_wd_state       = wd_state;
		next_wd_count       = wd_count;
		next_watchdog_reset = watchdog_reset;
		// A count written while the timer is still stopped parks the watchdog in the running state with
		// its count held, so it cannot fire before the timer has started. A count of zero never fires.
		case (wd_state)
			WD_IDLE: begin
				if (wr_wlow) begin
					next_wd_state = WD_RUN;
					next_wd_count = COUNT_WIDTH'({wcount_high, req.wdata});
				end
			end
			WD_RUN: begin
				if (wr_wlow) begin
					next_wd_count = COUNT_WIDTH'({wcount_high, req.wdata});
				end else if (wd_touch) begin
					next_wd_count = COUNT_WIDTH'({wcount_high, wcount_low});
				end else if (timer_started && wd_tick && wd_count != '0) begin
					next_wd_count = wd_count - COUNT_WIDTH'(1);
				end
				if (timer_started && wd_tick && wd_count == COUNT_WIDTH'(1) && !wr_wlow && !wd_touch) begin
					next_watchdog_reset = 1'b1;
				end
			end
			default: begin
				next_wd_state = WD_IDLE;
			end
		endcase
		if (wr_key && req.wdata != `WDOG_KEY) begin
			next_watchdog_reset = 1'b1;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		if (req.read) begin
			case (req.addr)
				`OFF_CONFIG:      next_rdata = config_reg;
				`OFF_PRESCALE:    next_rdata = {6'h00, prescale};
				`OFF_TCOUNT_HIGH: next_rdata = tcount_high;
				`OFF_TCOUNT_LOW:  next_rdata = tcount_low;
				`OFF_WCOUNT_LOW:  next_rdata = wcount_low;
				`OFF_WCOUNT_HIGH: next_rdata = wcount_high;
				`OFF_SCRATCH:     next_rdata = scratch;
				`OFF_VERSION:     next_rdata = VERSION_CODE;
				// Control and key are write-only strobes; reading them back must not hint at the key.
				`OFF_CONTROL:     next_rdata = 8'h00;
				`OFF_WKEY:        next_rdata = 8'h00;
				default:          next_rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			config_reg     <= `CONFIG_RESET;
			prescale       <= `PRESCALE_RESET;
			tcount_high    <= `TCOUNT_RESET;
			tcount_low     <= `TCOUNT_RESET;
			wcount_high    <= `WCOUNT_RESET;
			wcount_low     <= `WCOUNT_RESET;
			scratch        <= 8'h00;
		end else begin
			config_reg     <= next_config_reg;
			prescale       <= next_prescale;
			tcount_high    <= next_tcount_high;
			tcount_low     <= next_tcount_low;
			wcount_high    <= next_wcount_high;
			wcount_low     <= next_wcount_low;
			scratch        <= next_scratch;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_started  <= 1'b0;
			div_count      <= 10'h000;
			timer_count    <= '0;
			timer_irq      <= 1'b0;
		end else begin
			timer_started  <= next_timer_started;
			div_count      <= next_div_count;
			timer_count    <= next_timer_count;
			timer_irq      <= next_timer_irq;
		end
	end

	// The watchdog reset output holds until the block's own reset, which the reset it drives is
	// expected to cause; releasing it earlier would let a half-reset controller run on.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wd_count       <= '0;
			wd_state       <= WD_IDLE;
			watchdog_reset <= 1'b0;
		end else begin
			wd_count       <= next_wd_count;
			wd_state       <= next_wd_state;
			watchdog_reset <= next_watchdog_reset;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata          <= 8'h00;
		end else begin
			rdata          <= next_rdata;
		end
	end

endmodule

/* File: verif/external_timer_watchdog_checker.sv */
/* Port checker of the timer and watchdog block.
   Assumes it is bound into every instance of that block. */
`timescale 1ns/1ns
`include "etwd_regs.svh"
module external_timer_watchdog_checker
	import etwd_pkg::*;
#(
	parameter logic [7:0] VERSION_CODE = 8'h01
) (
	input wire logic               ref_clk,
	input wire logic               reset_n,
	input wire etwd_pkg::reg_req_t req,
	input wire logic               rtc_tick,
	input wire logic               host_memory_cycle,
	input wire logic [7:0]         rdata,
	input wire logic               timer_irq,
	input wire logic               watchdog_reset
);
	logic started;
	logic next_started;
	logic bad_key;
	logic good_key;

	assign bad_key = req.write && req.addr == `OFF_WKEY && req.wdata != `WDOG_KEY;
	assign good_key = req.write && req.addr == `OFF_WKEY && req.wdata == `WDOG_KEY;

	// Remembers the start write, because the checker cannot see the lock bits.
	always_comb begin
		next_started = started | (req.write && req.addr == `OFF_TCOUNT_LOW);
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			started <= 1'b0;
		end else begin
			started <= next_started;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	a_reset_stays_high: assert property (watchdog_reset |=> watchdog_reset)
		else $error("watchdog reset dropped");
	a_reset_has_cause: assert property ($rose(watchdog_reset) |->
		$past(bad_key) || (($past(rtc_tick) || $past(rtc_tick, 2)) && started))
		else $error("watchdog reset without cause");
	a_wrong_key_fires: assert property (bad_key |=> watchdog_reset)
		else $error("wrong key did not fire");
	a_good_key_quiet: assert property (good_key && !rtc_tick && !$past(rtc_tick)
		|=> !$rose(watchdog_reset))
		else $error("good key fired");
	a_timer_idle_first: assert property (!started |-> !timer_irq)
		else $error("timer ran before start");
	a_irq_after_tick: assert property (timer_irq |-> $past(rtc_tick))
		else $error("timer expiry without tick");
	a_irq_one_cycle: assert property (timer_irq |=> !timer_irq)
		else $error("timer irq too long");
	a_rdata_idle_zero: assert property (!req.read |=> rdata == 8'h00)
		else $error("read data without read");
	a_version_value: assert property (req.read && req.addr == `OFF_VERSION |=> rdata == VERSION_CODE)
		else $error("version value wrong");

	c_expiry: cover property (timer_irq);
	c_fire: cover property ($rose(watchdog_reset));
	c_wrong_key: cover property (bad_key);
endmodule

bind external_timer_watchdog external_timer_watchdog_checker #(
	.VERSION_CODE(VERSION_CODE)
) chk (
	.ref_clk(ref_clk),
	.reset_n(reset_n),
	.req(req),
	.rtc_tick(rtc_tick),
	.host_memory_cycle(host_memory_cycle),
	.rdata(rdata),
	.timer_irq(timer_irq),
	.watchdog_reset(watchdog_reset)
);

/* File: verif/external_timer_watchdog_tb.sv */
/* Self-checking bench of the timer and watchdog block.
   Assumes the package is compiled first; the bench makes rtc_tick itself. */
`timescale 1ns/1ns
module external_timer_watchdog_tb;
	import etwd_pkg::*;

	localparam logic [7:0] VER = 8'h3A;  // Arbitrary value.
	logic        ref_clk = 0;
	logic        reset_n = 0;
	reg_req_t    req = '0;
	logic        rtc_tick = 0;
	logic        host_memory_cycle = 0;
	logic [7:0]  rdata;
	logic        timer_irq;
	logic        watchdog_reset;
	int          errors = 0;
	int          cmp_count = 0;
	int          irqs = 0;
	int          n [4] = '{1, 32, 1024, 32};
	logic [7:0]  ro [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h20};
	logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00};
	logic [7:0]  lk [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
	logic [31:0] seed = 32'hA0C12C10;
	logic [7:0]  d;
	// ----------------------------------------
	// Behavioural model
	// ----------------------------------------
	// Mirrors every write and every tick from the rules alone, with plain integers.
	int          cfg_bits, ps_sel, t_high, t_low, w_high, w_low, div_ticks, t_count, w_count, irq_exp;
	bit          t_on, w_on, fire_exp;

	task automatic model_reset();
		cfg_bits = 0;
		ps_sel = 0;
		t_high = 8'hFF;
		t_low = 8'hFF;
		w_high = 8'hFF;
		w_low = 8'hFF;
		div_ticks = 0;
		t_count = 0;
		w_count = 0;
		irq_exp = 0;
		t_on = 0;
		w_on = 0;
		fire_exp = 0;
	endtask

	task automatic model_wr(input int a, input int v);
		case (a)
			1: if (!cfg_bits[0]) cfg_bits = (v & 8'h70) | ((v | cfg_bits) & 8'h0F);
			2: if (!cfg_bits[1]) ps_sel = v & 3;
			3: if (!cfg_bits[2]) t_high = v;
			4: if (!cfg_bits[2]) begin
				t_low = v;
				t_on = 1;
				t_count = t_high * 256 + v;
				div_ticks = 0;
			end
			5: if (t_on && v[0]) t_count = t_high * 256 + t_low;
			6: if (!cfg_bits[3]) begin
				w_low = v;
				w_on = 1;
				w_count = w_high * 256 + v;
			end
			7: if (v != 8'h5C) begin
				fire_exp = 1;
			end else if (cfg_bits[5] && w_on) begin
				w_count = w_high * 256 + w_low;
			end
			9: w_high = v;
			default: ;
		endcase
	endtask

	task automatic model_tick();
		bit pre;
		bit expire;
		bit wd_step;
		pre = 0;
		if (t_on) begin
			div_ticks++;
			pre = ps_sel == 0 || (ps_sel == 1 && div_ticks % 32 == 0) || (ps_sel == 2 && div_ticks % 1024 == 0);
		end
		expire = pre && t_count == 0;
		if (expire) begin
			irq_exp++;
			t_count = t_high * 256 + t_low;
		end else if (pre) begin
			t_count--;
		end
		wd_step = (cfg_bits[4] ? pre : expire) && !(cfg_bits[6] && host_memory_cycle);
		if (w_on && wd_step && w_count != 0) begin
			w_count--;
			if (w_count == 0) fire_exp = 1;
		end
	endtask

	external_timer_watchdog #(.VERSION_CODE(VER)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.req(req), .rtc_tick(rtc_tick), .host_memory_cycle(host_memory_cycle), .rdata(rdata),
		.timer_irq(timer_irq), .watchdog_reset(watchdog_reset));

	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (timer_irq === 1'b1) irqs++;

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("counts: %0d compares, %0d mismatches", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic rst();
		reset_n = 0;
		irqs = 0;
		model_reset();
		repeat (16) @(negedge ref_clk);
		reset_n = 1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge ref_clk);
		req = '{1'b1, 1'b0, a, v};
		model_wr(a, v);
		@(negedge ref_clk);
		req.write = 0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge ref_clk);
		req.read = 0;
		check(rdata, e);
	endtask

	// The idle cycles after each tick let a two-stage expiry path settle.
	task automatic tick(input int k);
		repeat (k) begin
			@(negedge ref_clk) rtc_tick = 1;
			model_tick();
			@(negedge ref_clk) rtc_tick = 0;
			repeat (2) @(negedge ref_clk);
			check(irqs[7:0], irq_exp[7:0]);
			check({7'h00, watchdog_reset}, {7'h00, fire_exp});
		end
	endtask

	// Timer reloads every two ticks; a key of zero means no key write.
	task automatic wd_case(input logic [7:0] cfg, input logic [15:0] cnt, input logic h,
		input int q, input int r, input logic [7:0] key, input logic e);
		rst();
		wr(8'h01, cfg);
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h01);
		wr(8'h09, cnt[15:8]);
		wr(8'h06, cnt[7:0]);
		host_memory_cycle = h;
		tick(q);
		check({7'h00, watchdog_reset}, 8'h00);
		if (key != 8'h00) wr(8'h07, key);
		host_memory_cycle = 0;
		tick(r);
		@(negedge ref_clk);
		check({7'h00, watchdog_reset}, {7'h00, e});
	endtask

	initial begin
		rst();
		foreach (ro[i]) rd(ro[i], rv[i]);
		d = rnd();
		wr(8'h08, d);
		rd(8'h08, d);
		wr(8'h10, ~VER);
		rd(8'h10, VER);
		wr(8'h01, 8'h70);
		rd(8'h01, 8'h70);
		$display("test registers done");
		foreach (lk[i]) begin
			rst();
			wr(8'h01, lk[i]);
			wr(8'h01, 8'h00);
			rd(8'h01, lk[i]);
			wr(8'h02, 8'h01);
			rd(8'h02, lk[i] == 8'h02 ? 8'h00 : 8'h01);
			wr(8'h03, 8'h00);
			rd(8'h03, lk[i] == 8'h04 ? 8'hFF : 8'h00);
		end
		$display("test locks done");
		for (int p = 0; p < 4; p++) begin
			rst();
			wr(8'h02, p[7:0]);
			wr(8'h03, 8'h00);
			wr(8'h04, 8'h01);
			tick(2 * n[p]);
			check(irqs[7:0], p == 3 ? 8'h00 : 8'h01);
			tick(2 * n[p]);
			check(irqs[7:0], p == 3 ? 8'h00 : 8'h02);
		end
		rst();
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h02);
		tick(2);
		wr(8'h05, 8'h01);
		tick(2);
		check(irqs[7:0], 8'h00);
		tick(1);
		check(irqs[7:0], 8'h01);
		$display("test timer done");
		rst();
		wr(8'h01, 8'h10);
		wr(8'h06, 8'h01);
		tick(3);
		check({7'h00, watchdog_reset}, 8'h00);
		check(irqs[7:0], 8'h00);
		wd_case(8'h10, 16'h0002, 0, 1, 1, 8'h00, 1);
		wd_case(8'h10, 16'h0100, 0, 255, 1, 8'h00, 1);
		wd_case(8'h00, 16'h0002, 0, 3, 1, 8'h00, 1);
		wd_case(8'h50, 16'h0002, 1, 3, 2, 8'h00, 1);
		wd_case(8'h18, 16'h0001, 0, 3, 0, 8'h00, 0);
		wd_case(8'h10, 16'h0003, 0, 2, 1, 8'h5C, 1);
		wd_case(8'h30, 16'h0003, 0, 2, 2, 8'h5C, 0);
		wd_case(8'h30, 16'h0010, 0, 1, 0, rnd() | 8'h01, 1);
		$display("test watchdog done");
		finish_test();
	end

	initial begin
		#5000000;
		errors++;
		finish_test();
	end
endmodule
